// ---- core/comparator_defines.vh ----
// constants for the comparator control block
// assumes inclusion by bare name from core design files
`ifndef COMPARATOR_DEFINES_VH
`define COMPARATOR_DEFINES_VH

// ********************************************************
// register map
// ********************************************************
`define CMP_CTRL_ADDR      12'h000
`define CMP_ADDR_W         12

// ********************************************************
// field positions
// ********************************************************
`define CMP_ENABLE_BIT     15
`define CMP_OE_BIT         14
`define CMP_INV_BIT        13
`define CMP_RESULT_BIT     8
`define CMP_EDGE_HI        7
`define CMP_EDGE_LO        6
`define CMP_POS_BIT        4
`define CMP_NEG_HI         1
`define CMP_NEG_LO         0

// ********************************************************
// reset values
// ********************************************************
`define CMP_EDGE_RESET     2'h3
`define CMP_NEG_RESET      2'h3

// ********************************************************
// edge select codes
// ********************************************************
`define CMP_EDGE_NONE      2'h0
`define CMP_EDGE_RISE      2'h1
`define CMP_EDGE_FALL      2'h2
`define CMP_EDGE_BOTH      2'h3

// ********************************************************
// negative input codes
// ********************************************************
`define CMP_NEG_PIN_B      2'h0
`define CMP_NEG_PIN_C      2'h1
`define CMP_NEG_PIN_D      2'h2
`define CMP_NEG_VREF       2'h3

`endif

// ---- core/comparator_sync.v ----
// two-stage synchroniser with edge pulses
// assumes the input is asynchronous to pclk
`timescale 1ns/1ps
module comparator_sync
(
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output wire sync_out,
    output wire rise_pulse,
    output wire fall_pulse
);

reg stage1_r;
reg stage2_r;
reg stage3_r;

// ********************************************************
// synchroniser
// ********************************************************
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        stage1_r <= 1'b0;
        stage2_r <= 1'b0;
        stage3_r <= 1'b0;
    end
    else
    begin
        stage1_r <= async_in;
        stage2_r <= stage1_r;
        stage3_r <= stage2_r;
    end
end

assign sync_out   = stage2_r;
assign rise_pulse = stage2_r & ~stage3_r;
assign fall_pulse = ~stage2_r & stage3_r;

endmodule // comparator_sync

// ---- core/comparator_control.v ----
// comparator channel control register and interrupt edge logic
// assumes an apb master on pclk and an analog core outside
// the core sees enable and both input selects as levels
// the raw comparator output arrives with no relation to pclk
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "comparator_defines.vh"

// Summary of operation
// - enable bit 15 turns comparator on
// - clear enable powers down, fields kept
// - output enable bit 14 drives pin while enable bit 15 is set
// - polarity bit 13 inverts result
// - bit 8 reads comparator result
// - edge field selects both, fall, rise
// - edge code 00 gives no interrupt
// - inversion also feeds edge detector
// - bit 4 picks reference or pin a
// - bits 1-0 pick b, c, d, reference
// - unimplemented bits read zero, ignore writes
module comparator_control
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        comparator_raw,
    output wire        comparator_enable,
    output wire        positive_input_select,
    output wire [1:0]  negative_input_select,
    output wire        comparator_output_pin,
    output wire        comparator_output_pin_oe_n,
    output wire        comparator_interrupt
);

reg        enable_r;
reg        oe_r;
reg        invert_r;
reg  [1:0] edge_sel_r;
reg        pos_sel_r;
reg  [1:0] neg_sel_r;
reg        pin_r;
reg        irq_r;
reg  [31:0] rdata_r;
wire       sync_level;
wire       raw_rise;
wire       raw_fall;
wire       result;
wire       res_rise;
wire       res_fall;
wire       hit;
wire       wr;
wire       rd;
wire [31:0] ctrl_view;
wire [31:0] ctrl_fields;
wire [1:0]  lane_we;
wire        in_setup;
reg  [2:0]  bus_state_r;
reg  [2:0]  bus_state_nxt;
reg         enable_nxt;
reg         oe_nxt;
reg         invert_nxt;
reg  [1:0]  edge_sel_nxt;
reg         pos_sel_nxt;
reg  [1:0]  neg_sel_nxt;
reg         pin_nxt;
reg         irq_nxt;
reg         oe_n_r;
reg         oe_n_nxt;
reg  [31:0] rdata_nxt;

// ********************************************************
// local constants
// ********************************************************
localparam [11:0] CTRL_BYTE = `CMP_CTRL_ADDR;
localparam [2:0]  ST_IDLE   = 3'b001;
localparam [2:0]  ST_SETUP  = 3'b010;
localparam [2:0]  ST_ACCESS = 3'b100;

// ********************************************************
// decode functions
// ********************************************************
// byte lane that carries a control field bit
function lane_of;
    input integer pos;
    begin
        lane_of = pos[3];
    end
endfunction

// true for a control bit that software can see
function bit_live;
    input integer pos;
    begin
        bit_live = (pos == `CMP_ENABLE_BIT)
                || (pos == `CMP_OE_BIT)
                || (pos == `CMP_INV_BIT)
                || (pos == `CMP_RESULT_BIT)
                || (pos == `CMP_EDGE_HI)
                || (pos == `CMP_EDGE_LO)
                || (pos == `CMP_POS_BIT)
                || (pos == `CMP_NEG_HI)
                || (pos == `CMP_NEG_LO);
    end
endfunction

// edge field decode, code 00 takes nothing
function edge_take;
    input [1:0] code;
    input       rise;
    input       fall;
    begin
        case (code)
            `CMP_EDGE_BOTH: edge_take = rise | fall;
            `CMP_EDGE_FALL: edge_take = fall;
            `CMP_EDGE_RISE: edge_take = rise;
            default:        edge_take = 1'b0;
        endcase
    end
endfunction

// ********************************************************
// synchronise comparator output
// ********************************************************
comparator_sync u_sync
(
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (comparator_raw),
    .sync_out   (sync_level),
    .rise_pulse (raw_rise),
    .fall_pulse (raw_fall)
);

// ********************************************************
// result polarity
// ********************************************************
// inversion applies to result and edge detector
assign result   = sync_level ^ invert_r;
assign res_rise = invert_r ? raw_fall : raw_rise;
assign res_fall = invert_r ? raw_rise : raw_fall;

// ********************************************************
// apb decode
// ********************************************************
assign hit     = (paddr[11:2] == CTRL_BYTE[11:2]);
assign wr      = psel & penable & pwrite & hit & in_setup;
assign rd      = psel & ~penable & ~pwrite;
assign pready  = 1'b1;
assign pslverr = psel & penable & ~hit & in_setup;

// ********************************************************
// apb phase tracker
// ********************************************************
// a write lands only in the access phase right after
// a setup phase, so a stuck penable cannot write twice
always @*
begin
    bus_state_nxt = ST_IDLE;
    case (bus_state_r)
        ST_IDLE:
        begin
            if (psel & ~penable)
                bus_state_nxt = ST_SETUP;
        end
        ST_SETUP:
        begin
            if (psel & penable)
                bus_state_nxt = ST_ACCESS;
            else if (psel)
                bus_state_nxt = ST_SETUP;
        end
        ST_ACCESS:
        begin
            if (psel & ~penable)
                bus_state_nxt = ST_SETUP;
        end
        default:
        begin
            // unknown codes fall back to idle
            bus_state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        bus_state_r <= ST_IDLE;
    else
        bus_state_r <= bus_state_nxt;
end

assign in_setup = (bus_state_r == ST_SETUP);

// ********************************************************
// byte lane write enables
// ********************************************************
// lanes 2 and 3 hold no fields
genvar lane;
generate
    for (lane = 0; lane < 2; lane = lane + 1)
    begin : g_lane
        assign lane_we[lane] = wr & pstrb[lane];
    end
endgenerate

// readback fields in place, then masked to the live bits
assign ctrl_fields = {16'h0000, enable_r, oe_r, invert_r, 4'h0,
                      result, edge_sel_r, 1'b0, pos_sel_r, 2'h0,
                      neg_sel_r};

genvar vbit;
generate
    for (vbit = 0; vbit < 32; vbit = vbit + 1)
    begin : g_view
        assign ctrl_view[vbit] = ctrl_fields[vbit] & bit_live(vbit);
    end
endgenerate

// ********************************************************
// control register
// ********************************************************
// each field moves only when its own byte lane is written;
// enable never disturbs the other fields
always @*
begin
    enable_nxt   = enable_r;
    oe_nxt       = oe_r;
    invert_nxt   = invert_r;
    edge_sel_nxt = edge_sel_r;
    pos_sel_nxt  = pos_sel_r;
    neg_sel_nxt  = neg_sel_r;
    if (lane_we[lane_of(`CMP_ENABLE_BIT)])
        enable_nxt = pwdata[`CMP_ENABLE_BIT];
    if (lane_we[lane_of(`CMP_OE_BIT)])
        oe_nxt = pwdata[`CMP_OE_BIT];
    if (lane_we[lane_of(`CMP_INV_BIT)])
        invert_nxt = pwdata[`CMP_INV_BIT];
    if (lane_we[lane_of(`CMP_EDGE_HI)])
        edge_sel_nxt = pwdata[`CMP_EDGE_HI:`CMP_EDGE_LO];
    if (lane_we[lane_of(`CMP_POS_BIT)])
        pos_sel_nxt = pwdata[`CMP_POS_BIT];
    if (lane_we[lane_of(`CMP_NEG_HI)])
        neg_sel_nxt = pwdata[`CMP_NEG_HI:`CMP_NEG_LO];
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        enable_r   <= 1'b0;
        oe_r       <= 1'b0;
        invert_r   <= 1'b0;
        edge_sel_r <= `CMP_EDGE_RESET;
        pos_sel_r  <= 1'b0;
        neg_sel_r  <= `CMP_NEG_RESET;
    end
    else
    begin
        enable_r   <= enable_nxt;
        oe_r       <= oe_nxt;
        invert_r   <= invert_nxt;
        edge_sel_r <= edge_sel_nxt;
        pos_sel_r  <= pos_sel_nxt;
        neg_sel_r  <= neg_sel_nxt;
    end
end

// ********************************************************
// read data
// ********************************************************
// captured in the setup phase and held until the next read
always @*
begin
    rdata_nxt = rdata_r;
    if (rd)
    begin
        if (hit)
            rdata_nxt = ctrl_view;
        else
            rdata_nxt = 32'h00000000;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        rdata_r <= 32'h00000000;
    else
        rdata_r <= rdata_nxt;
end

assign prdata = rdata_r;

// ********************************************************
// output pin and interrupt pulse
// ********************************************************
// the pin is released whenever the module is off
// oe_n follows the next fields so it moves with the write
always @*
begin
    pin_nxt  = result;
    oe_n_nxt = ~(oe_nxt & enable_nxt);
    irq_nxt  = enable_r
             & edge_take(edge_sel_r, res_rise, res_fall);
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_r  <= 1'b0;
        irq_r  <= 1'b0;
        oe_n_r <= 1'b1;
    end
    else
    begin
        pin_r  <= pin_nxt;
        irq_r  <= irq_nxt;
        oe_n_r <= oe_n_nxt;
    end
end

// ********************************************************
// analog side outputs
// ********************************************************
assign comparator_enable          = enable_r;
assign comparator_output_pin      = pin_r;
assign comparator_output_pin_oe_n = oe_n_r;
assign comparator_interrupt       = irq_r;
assign positive_input_select      = pos_sel_r;
assign negative_input_select      = neg_sel_r;

endmodule // comparator_control

// ---- verification/comparator_core_model.sv ----
// far-side model: comparator core and its input muxes
// assumes levels va and nv come from the bench
`timescale 1ns/1ps
module comparator_core_model
(
    input                   comparator_enable,
    input                   positive_input_select,
    input       [1:0]       negative_input_select,
    input       [3:0]       va,
    input logic [3:0][3:0]  nv,
    output                  comparator_raw
);
    assign comparator_raw = comparator_enable &&
        (positive_input_select ? nv[3] : va) >
        nv[negative_input_select];
endmodule // comparator_core_model

// ---- verification/comparator_control_props.sv ----
// assertions on the comparator_control ports
// assumes bind into comparator_control
`timescale 1ns/1ps
module comparator_control_props
(
    input        pclk, presetn, psel, penable, pwrite, pslverr,
    input        comparator_raw, comparator_enable, positive_input_select,
    input        comparator_output_pin_oe_n, comparator_interrupt,
    input [1:0]  negative_input_select,
    input [3:0]  pstrb,
    input [11:0] paddr,
    input [31:0] pwdata, prdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr = acc && pwrite && paddr == 12'h000;
    wire irq = comparator_interrupt;
    a_select_write: assert property (wr && pstrb[0] |=>
        {positive_input_select, negative_input_select} ==
        {$past(pwdata[4]), $past(pwdata[1:0])}) else $error("select");
    a_enable_write: assert property (wr && pstrb[1] |=>
        comparator_enable == $past(pwdata[15])) else $error("enable");
    a_fields_kept: assert property (wr && pstrb == 4'h2 |=>
        $stable(negative_input_select)) else $error("kept");
    a_pin_drive: assert property (wr && pstrb[1] |=>
        comparator_output_pin_oe_n != $past(pwdata[15] && pwdata[14]))
        else $error("pin enable");
    a_unused_zero: assert property (acc && !pwrite |->
        (prdata & 32'hFFFF1E2C) == 32'h0) else $error("unused bit");
    a_unmapped_err: assert property (acc && paddr != 12'h000 |->
        pslverr) else $error("slave error");
    a_irq_cause: assert property (irq |->
        $past(comparator_raw, 3) != $past(comparator_raw, 4))
        else $error("interrupt without edge");
    a_irq_gated: assert property (irq |-> $past(comparator_enable))
        else $error("interrupt while off");
    cover property (wr);
    cover property (irq);
    cover property (pslverr);
endmodule // comparator_control_props
bind comparator_control comparator_control_props
    u_comparator_control_props (.*);

// ---- verification/comparator_control_tb_top.sv ----
// bench for comparator_control with the core model
// assumes zero wait state apb at 50 MHz
`timescale 1ns/1ps
module comparator_control_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, err, comparator_raw, comparator_enable;
    logic positive_input_select, comparator_output_pin, e;
    logic comparator_output_pin_oe_n, comparator_interrupt;
    logic [1:0] negative_input_select;
    logic [3:0] pstrb = 0, va = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0][3:0] nv = {4'h9, 4'h7, 4'h9, 4'h7};
    int miscompares = 0, num_checks = 0, cyc = 0, irq_n = 0, c;
    comparator_control u_comparator_control (.*);
    comparator_core_model u_comparator_core_model (.*);
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        irq_n <= irq_n + (comparator_interrupt === 1'b1);
        if (cyc == 3000) test_done;
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            $display("wrong value %0t %h %h", $time, g, x);
            miscompares++;
        end
    endtask
    task test_done;
        if (cyc >= 3000) miscompares++;
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task t_fields;
        apb(0, 12'h000, 32'h0, 4'h0);
        chk(rd, 32'h000000C3);
        apb(1, 12'h000, 32'hFFFFFFFF, 4'hF);
        apb(0, 12'h000, 32'h0, 4'h0);
        chk(rd, 32'h0000E1D3);
        chk(comparator_output_pin, 1'b1);
        apb(1, 12'h000, 32'h0, 4'h2);
        apb(1, 12'h004, 32'h0, 4'hF);
        chk(err, 1'b1);
        apb(0, 12'h000, 32'h0, 4'h0);
        chk(rd, 32'h000000D3);
        chk(comparator_output_pin_oe_n, 1'b1);
    endtask
    task t_mux;
        va <= 4'h8;
        for (int n = 0; n < 5; n++) begin
            apb(1, 12'h000, 32'h0000C000 | (n == 4 ? 32'h10 : n), 4'h3);
            repeat (4) @(posedge pclk);
            apb(0, 12'h000, 32'h0, 4'h0);
            e = n == 4 || n % 2 == 0;
            chk(rd[8], e);
            chk(comparator_output_pin, e);
        end
        chk(irq_n, 32'h0);
    endtask
    task t_irq;
        for (int k = 0; k < 8; k++) begin
            va <= 4'h0;
            apb(1, 12'h000, 32'h0000C000 | k[2] << 13 | k[1:0] << 6, 4'h3);
            repeat (6) @(posedge pclk);
            c = irq_n;
            va <= 4'h8;
            repeat (8) @(posedge pclk);
            chk(irq_n - c, k[2] ? k[1] : k[0]);
            chk(comparator_output_pin, !k[2]);
            va <= 4'h0;
            repeat (8) @(posedge pclk);
            chk(irq_n - c, {1'b0, k[0]} + k[1]);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_fields;
        t_mux;
        t_irq;
        test_done;
    end
endmodule // comparator_control_tb_top
